// [shared/cts_pkg.sv]
`default_nettype none
package cts_pkg;

  // Byte addresses of the registers on the AHB-Lite slave.
  localparam logic [31:0] CTS_OFF_STAMP_CTRL = 32'h0000_0000;
  localparam logic [31:0] CTS_OFF_BIT_TIMING = 32'h0000_0004;
  localparam logic [31:0] CTS_OFF_STATUS     = 32'h0000_0008;

  // Register indices produced by the address decoder.
  localparam logic [1:0] CTS_IDX_STAMP_CTRL = 2'h0;
  localparam logic [1:0] CTS_IDX_BIT_TIMING = 2'h1;
  localparam logic [1:0] CTS_IDX_STATUS     = 2'h2;
  localparam logic [1:0] CTS_IDX_NONE       = 2'h3;

  // Field positions in the stamp control register.
  localparam int CTS_POS_ENABLE   = 0;
  localparam int CTS_POS_TRIG_SEL = 1;
  localparam int CTS_POS_LOCK     = 2;
  localparam int CTS_POS_TOGGLE   = 8;

  // Field positions in the bit timing register.
  localparam int CTS_POS_SEG1  = 0;
  localparam int CTS_POS_SEG2  = 8;
  localparam int CTS_POS_SJW   = 12;
  localparam int CTS_POS_PRESC = 16;

  // Field positions in the status register.
  localparam int CTS_POS_TIMING_OK = 0;
  localparam int CTS_POS_SAMPLED   = 1;

  // Values after reset; the bit timing default is a legal 8-quantum bit.
  localparam logic       CTS_RST_ENABLE   = 1'b0;
  localparam logic       CTS_RST_TRIG_SEL = 1'b0;
  localparam logic       CTS_RST_LOCK     = 1'b0;
  localparam logic       CTS_RST_TOGGLE   = 1'b0;
  localparam logic [3:0] CTS_RST_SEG1     = 4'h3;
  localparam logic [2:0] CTS_RST_SEG2     = 3'h2;
  localparam logic [1:0] CTS_RST_SJW      = 2'h0;
  localparam logic [7:0] CTS_RST_PRESC    = 8'h00;

  // Legal ranges, counted in time quanta.
  localparam logic [5:0] CTS_SPT_MIN = 6'h05;
  localparam logic [5:0] CTS_SPT_MAX = 6'h11;
  localparam logic [5:0] CTS_DBT_MIN = 6'h08;
  localparam logic [5:0] CTS_DBT_MAX = 6'h19;

  // Message buffer whose storing locks the stamp.
  localparam int         CTS_BUF_W    = 6;
  localparam logic [5:0] CTS_BUF_LOCK = 6'h00;

  // Frame events reported by the protocol engine, one cycle each.
  typedef struct packed {
    logic                 sof;
    logic                 eof;
    logic                 data_frame;
    logic                 store_start;
    logic                 store_remote;
    logic [CTS_BUF_W-1:0] store_buffer;
  } cts_rx_event_t;

endpackage : cts_pkg
`default_nettype wire

// [design/cts_quantum_div.sv]
`timescale 1ns/1ps
`default_nettype none
module cts_quantum_div (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] presc,
  output logic            tq_en
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } cts_div_state_t;

  cts_div_state_t q;
  cts_div_state_t next_q;

  // One quantum is presc+1 clock periods; all segments count these ticks.
  always_comb begin
    next_q      = q;
    next_q.tick = 1'b0;
    if (q.cnt >= presc) begin
      next_q.cnt  = 8'h00;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tq_en = q.tick;

  tick_spacing_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.tick && presc == 8'h01 && $stable(presc) |=> !q.tick ##1 q.tick)
    else $error("Quantum tick spacing wrong.");

endmodule : cts_quantum_div
`default_nettype wire

// [design/cts_bit_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module cts_bit_timer (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tq_en,
  input  wire logic       rx_bit_in,
  input  wire logic [3:0] seg1,
  input  wire logic [2:0] seg2,
  output logic            sampled_bit,
  output logic            sample_strobe
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       rx_prev;
    logic       sampled;
    logic       strobe;
  } cts_bt_state_t;

  cts_bt_state_t q;
  cts_bt_state_t next_q;
  logic [4:0]    spt_pos;
  logic [4:0]    last_pos;

  // Quantum 0 is the sync quantum; segment one follows it.
  assign spt_pos  = {1'b0, seg1} + 5'h01;
  assign last_pos = spt_pos + {2'h0, seg2} + 5'h01;

  // A recessive-to-dominant edge restarts the bit; no phase error
  // correction is done, so long frames rely on close oscillators.
  always_comb begin
    next_q        = q;
    next_q.strobe = 1'b0;
    if (tq_en) begin
      next_q.rx_prev = rx_bit_in;
      if (q.rx_prev && !rx_bit_in) begin
        next_q.cnt = 5'h01;
      end else if (q.cnt >= last_pos) begin
        next_q.cnt = 5'h00;
      end else begin
        next_q.cnt = q.cnt + 5'h01;
      end
      if (q.cnt == spt_pos) begin
        next_q.sampled = rx_bit_in;
        next_q.strobe  = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{cnt: 5'h00, rx_prev: 1'b1, sampled: 1'b1, strobe: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign sampled_bit   = q.sampled;
  assign sample_strobe = q.strobe;

  sample_point_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.strobe |-> $past(tq_en) && $past(q.cnt) == $past(spt_pos))
    else $error("Sample taken off the sample point.");

  sample_value_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tq_en && q.cnt == spt_pos |=> q.strobe && q.sampled == $past(rx_bit_in))
    else $error("Bus level not sampled at quantum boundary.");

endmodule : cts_bit_timer
`default_nettype wire

// [design/cts_top.sv]
// Overview of operation
// - Capture output toggles on each selected data frame event.
// - Select bit: 0 start, 1 end of frame.
// - Toggling only while stamp enable is set.
// - Without lock, toggling never stops by itself.
// - With lock, buffer 0 store clears enable.
// - Only buffer 0 data frames stop toggling.
// - Remote frames never stop the toggling.
// - Segment one: bits 3:0, length minus one.
// - Segment two: bits 10:8, length minus one.
// - One quantum is presc+1 protocol clock periods.
`timescale 1ns/1ps
`default_nettype none
module cts_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  rx_bit_in,
  input  wire cts_pkg::cts_rx_event_t rx_event,
  output logic                       capture_toggle_out,
  output logic                       sampled_bit,
  output logic                       sample_strobe
);

  typedef struct packed {
    logic        stamp_enable;
    logic        trigger_source_select;
    logic        stamp_lock;
    logic        toggle;
    logic [3:0]  seg1;
    logic [2:0]  seg2;
    logic [1:0]  resync_jump_width;
    logic [7:0]  presc;
    logic        wr_pend;
    logic [1:0]  wr_idx;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
  } cts_top_state_t;

  cts_top_state_t q;
  cts_top_state_t next_q;
  logic           tq_en;
  logic           ev_hit;
  logic           lock_hit;
  logic           addr_ok;
  logic           ctrl_wr;

  // Maps a byte address to a register index; used for reads and writes.
  function automatic logic [1:0] cts_reg_index(input logic [31:0] a);
    logic [1:0] idx;
    idx = cts_pkg::CTS_IDX_NONE;
    if (a == cts_pkg::CTS_OFF_STAMP_CTRL) begin
      idx = cts_pkg::CTS_IDX_STAMP_CTRL;
    end else if (a == cts_pkg::CTS_OFF_BIT_TIMING) begin
      idx = cts_pkg::CTS_IDX_BIT_TIMING;
    end else if (a == cts_pkg::CTS_OFF_STATUS) begin
      idx = cts_pkg::CTS_IDX_STATUS;
    end
    return idx;
  endfunction : cts_reg_index

  // Checks a bit timing setting against the legal quanta ranges.
  function automatic logic cts_timing_ok(input logic [3:0] s1,
                                         input logic [2:0] s2,
                                         input logic [1:0] jw);
    logic [5:0] sample_point_quanta;
    logic [5:0] bit_length_quanta;
    logic [5:0] jump;
    sample_point_quanta  = {2'h0, s1} + 6'h02;
    bit_length_quanta  = sample_point_quanta + {3'h0, s2} + 6'h01;
    jump = {4'h0, jw} + 6'h01;
    return (sample_point_quanta >= cts_pkg::CTS_SPT_MIN) && (sample_point_quanta <= cts_pkg::CTS_SPT_MAX)
        && (bit_length_quanta >= cts_pkg::CTS_DBT_MIN) && (bit_length_quanta <= cts_pkg::CTS_DBT_MAX)
        && (jump <= bit_length_quanta - sample_point_quanta);
  endfunction : cts_timing_ok

  // Only data frames toggle; the select bit picks the edge of the frame.
  assign ev_hit = rx_event.data_frame
               && (q.trigger_source_select ? rx_event.eof
                                           : rx_event.sof);

  // Remote frames cannot land in a receive buffer, so they never lock.
  assign lock_hit = rx_event.store_start && !rx_event.store_remote
                 && rx_event.store_buffer == cts_pkg::CTS_BUF_LOCK;

  assign addr_ok = hsel && htrans[1] && hready;
  assign ctrl_wr = q.wr_pend && q.wr_idx == cts_pkg::CTS_IDX_STAMP_CTRL;

  always_comb begin
    next_q       = q;
    next_q.ready = 1'b1;
    next_q.resp  = 1'b0;

    if (q.stamp_enable && ev_hit) begin
      next_q.toggle = ~q.toggle;
    end

    // Data phase of a write: the bus master drives hwdata now.
    if (q.wr_pend) begin
      case (q.wr_idx)
        cts_pkg::CTS_IDX_STAMP_CTRL: begin
          next_q.stamp_enable          = hwdata[cts_pkg::CTS_POS_ENABLE];
          next_q.trigger_source_select = hwdata[cts_pkg::CTS_POS_TRIG_SEL];
          next_q.stamp_lock            = hwdata[cts_pkg::CTS_POS_LOCK];
        end
        cts_pkg::CTS_IDX_BIT_TIMING: begin
          next_q.seg1  = hwdata[cts_pkg::CTS_POS_SEG1 +: 4];
          next_q.seg2  = hwdata[cts_pkg::CTS_POS_SEG2 +: 3];
          next_q.resync_jump_width   = hwdata[cts_pkg::CTS_POS_SJW +: 2];
          next_q.presc = hwdata[cts_pkg::CTS_POS_PRESC +: 8];
        end
        default: begin
        end
      endcase
    end

    // The hardware clear beats a same-cycle software set: once the locked
    // frame is being stored, the captured stamp must stay with it.
    if (q.stamp_lock && lock_hit) begin
      next_q.stamp_enable = 1'b0;
    end

    // Address phase; read data are built from the updated copy so that a
    // read right behind a write already sees the new value.
    next_q.wr_pend = addr_ok && hwrite;
    next_q.wr_idx  = cts_reg_index(haddr);
    if (addr_ok && !hwrite) begin
      next_q.rdata = 32'h0000_0000;
      case (cts_reg_index(haddr))
        cts_pkg::CTS_IDX_STAMP_CTRL: begin
          next_q.rdata[cts_pkg::CTS_POS_ENABLE]   = next_q.stamp_enable;
          next_q.rdata[cts_pkg::CTS_POS_TRIG_SEL] =
            next_q.trigger_source_select;
          next_q.rdata[cts_pkg::CTS_POS_LOCK]     = next_q.stamp_lock;
          next_q.rdata[cts_pkg::CTS_POS_TOGGLE]   = next_q.toggle;
        end
        cts_pkg::CTS_IDX_BIT_TIMING: begin
          next_q.rdata[cts_pkg::CTS_POS_SEG1 +: 4]  = next_q.seg1;
          next_q.rdata[cts_pkg::CTS_POS_SEG2 +: 3]  = next_q.seg2;
          next_q.rdata[cts_pkg::CTS_POS_SJW +: 2]   = next_q.resync_jump_width;
          next_q.rdata[cts_pkg::CTS_POS_PRESC +: 8] = next_q.presc;
        end
        cts_pkg::CTS_IDX_STATUS: begin
          next_q.rdata[cts_pkg::CTS_POS_TIMING_OK] =
            cts_timing_ok(next_q.seg1, next_q.seg2, next_q.resync_jump_width);
          next_q.rdata[cts_pkg::CTS_POS_SAMPLED] = sampled_bit;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.stamp_enable          <= cts_pkg::CTS_RST_ENABLE;
      q.trigger_source_select <= cts_pkg::CTS_RST_TRIG_SEL;
      q.stamp_lock            <= cts_pkg::CTS_RST_LOCK;
      q.toggle                <= cts_pkg::CTS_RST_TOGGLE;
      q.seg1                  <= cts_pkg::CTS_RST_SEG1;
      q.seg2                  <= cts_pkg::CTS_RST_SEG2;
      q.resync_jump_width                   <= cts_pkg::CTS_RST_SJW;
      q.presc                 <= cts_pkg::CTS_RST_PRESC;
      q.wr_pend               <= 1'b0;
      q.wr_idx                <= cts_pkg::CTS_IDX_NONE;
      q.rdata                 <= 32'h0000_0000;
      q.ready                 <= 1'b1;
      q.resp                  <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign hrdata             = q.rdata;
  assign hreadyout          = q.ready;
  assign hresp              = q.resp;
  assign capture_toggle_out = q.toggle;

  cts_quantum_div u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .presc   (q.presc),
    .tq_en   (tq_en)
  );

  cts_bit_timer u_bt (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .tq_en         (tq_en),
    .rx_bit_in     (rx_bit_in),
    .seg1          (q.seg1),
    .seg2          (q.seg2),
    .sampled_bit   (sampled_bit),
    .sample_strobe (sample_strobe)
  );

  default clocking cts_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  toggle_on_event_a: assert property (
    q.stamp_enable && ev_hit |=>
      capture_toggle_out != $past(capture_toggle_out))
    else $error("Capture output missed a selected event.");

  sof_select_a: assert property (
    !q.trigger_source_select && rx_event.data_frame
      && rx_event.eof && !rx_event.sof |=> $stable(capture_toggle_out))
    else $error("End of frame toggled with start selected.");

  eof_select_a: assert property (
    q.trigger_source_select && rx_event.data_frame
      && rx_event.sof && !rx_event.eof |=> $stable(capture_toggle_out))
    else $error("Start of frame toggled with end selected.");

  toggle_hold_a: assert property (
    !q.stamp_enable |=> $stable(capture_toggle_out))
    else $error("Capture output moved while disabled.");

  nolock_keep_a: assert property (
    q.stamp_enable && !q.stamp_lock && !ctrl_wr |=> q.stamp_enable)
    else $error("Enable dropped without lock.");

  lock_stop_a: assert property (
    q.stamp_lock && lock_hit |=>
      !q.stamp_enable ##1 $stable(capture_toggle_out))
    else $error("Toggle not stopped after locked store.");

  // The hardware clear must also win over a software write that sets
  // the enable bit in the very cycle the locked store begins.
  lock_wins_a: assert property (
    q.stamp_lock && lock_hit |=> !q.stamp_enable)
    else $error("Enable survived the locked store.");

  other_buf_a: assert property (
    q.stamp_enable && rx_event.store_start && !ctrl_wr
      && rx_event.store_buffer != cts_pkg::CTS_BUF_LOCK |=> q.stamp_enable)
    else $error("Store to another buffer stopped toggling.");

  remote_keep_a: assert property (
    q.stamp_enable && rx_event.store_start && rx_event.store_remote
      && !ctrl_wr |=> q.stamp_enable)
    else $error("Remote frame stopped toggling.");

  seg_fields_a: assert property (
    q.wr_pend && q.wr_idx == cts_pkg::CTS_IDX_BIT_TIMING |=>
      q.seg1 == $past(hwdata[3:0]) && q.seg2 == $past(hwdata[10:8]))
    else $error("Segment fields taken from wrong bits.");

  bus_okay_a: assert property (
    addr_ok |=> hreadyout && !hresp)
    else $error("Slave did not answer OKAY with zero wait.");

  // Read data stand through the data phase, so a slow master still sees
  // them; only a new read address phase may replace them.
  read_hold_a: assert property (
    !(addr_ok && !hwrite) |=> $stable(hrdata))
    else $error("Read data moved outside a read.");

endmodule : cts_top
`default_nettype wire

// [test/cts_can_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module cts_can_partner (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   capture_toggle_out,
  output var cts_pkg::cts_rx_event_t  rx_event,
  output logic                        rx_bit_in
);
  int edges;
  initial begin
    rx_event = '0;
    rx_bit_in = 1'b1;
    edges = 0;
  end
  // Both edges are counted, so no time stamp is lost.
  always @(capture_toggle_out) begin
    if (hresetn) begin
      edges++;
    end
  end
  // Buffer 0 is a receive buffer, so only its data stores lock.
  task automatic pulse(input logic sof, input logic eof, input logic df,
                       input logic st, input logic rem,
                       input logic [5:0] b);
    @(posedge hclk);
    rx_event <= '{sof, eof, df, st, rem, b};
    @(posedge hclk);
    rx_event <= '0;
  endtask : pulse
  // The bus idles recessive, the pull-up level.
  task automatic bus_level(input logic v);
    @(posedge hclk);
    rx_bit_in <= v;
  endtask : bus_level
endmodule : cts_can_partner
`default_nettype wire

// [test/can_time_stamp_and_bit_timing_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module can_time_stamp_and_bit_timing_bench;
  // Row fields, high bit first: sel, enable, frame, sof, eof, flip.
  typedef struct packed {
    logic sel;
    logic en;
    logic df;
    logic sof;
    logic eof;
    logic flip;
  } cts_ev_row_t;
  typedef struct packed {
    logic [3:0] s1;
    logic [2:0] s2;
    logic [1:0] jw;
    logic [7:0] pr;
    logic       ok;
  } cts_tm_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rx_bit_in;
  logic        capture_toggle_out;
  logic        sampled_bit;
  logic        sample_strobe;
  logic        exp_tog = 1'b0;
  logic [31:0] rd;
  int          n;
  int          flips = 0;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  cts_pkg::cts_rx_event_t rx_event;
  cts_ev_row_t ev_rows [7] = '{6'h1d, 6'h1a, 6'h3b, 6'h3c, 6'h0c, 6'h14,
                               6'h32};
  cts_tm_row_t tm_rows [4] = '{'{4'hf, 3'h7, 2'h3, 8'h00, 1'b1},
                               '{4'h5, 3'h0, 2'h0, 8'h01, 1'b1},
                               '{4'h3, 3'h2, 2'h0, 8'h00, 1'b1},
                               '{4'h3, 3'h2, 2'h3, 8'h00, 1'b0}};

  always #12.5 hclk = ~hclk;

  cts_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_bit_in(rx_bit_in), .rx_event(rx_event),
    .capture_toggle_out(capture_toggle_out), .sampled_bit(sampled_bit),
    .sample_strobe(sample_strobe));
  cts_can_partner p (.hclk(hclk), .hresetn(hresetn),
    .capture_toggle_out(capture_toggle_out), .rx_event(rx_event),
    .rx_bit_in(rx_bit_in));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb

  task automatic tog(input logic f);
    #1;
    exp_tog ^= f;
    flips += f;
    chk("capture toggle", {31'h0, exp_tog}, {31'h0, capture_toggle_out});
  endtask : tog

  // The first strobe after a change may still use the old timing.
  task automatic strobe_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin
        @(posedge hclk);
        #1;
        g++;
      end while (sample_strobe !== 1'b1 && g < 300);
    end
  endtask : strobe_gap

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk("reset outputs", 32'h2, {29'h0, capture_toggle_out, sampled_bit, hresp});
    ahb(1'b0, cts_pkg::CTS_OFF_BIT_TIMING, 32'h0, rd);
    chk("timing reset", 32'h0000_0203, rd);
    ahb(1'b0, 32'h0000_000c, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    foreach (ev_rows[i]) begin
      ahb(1'b1, cts_pkg::CTS_OFF_STAMP_CTRL,
          {30'h0, ev_rows[i].sel, ev_rows[i].en}, rd);
      p.pulse(ev_rows[i].sof, ev_rows[i].eof, ev_rows[i].df, 1'b0, 1'b0, 6'h0);
      tog(ev_rows[i].flip);
    end
    foreach (tm_rows[i]) begin
      ahb(1'b1, cts_pkg::CTS_OFF_BIT_TIMING, {8'h0, tm_rows[i].pr, 2'h0,
          tm_rows[i].jw, 1'b0, tm_rows[i].s2, 4'h0, tm_rows[i].s1},
          rd);
      ahb(1'b0, cts_pkg::CTS_OFF_BIT_TIMING, 32'h0, rd);
      chk("timing fields", {21'h0, tm_rows[i].s2, 4'h0, tm_rows[i].s1},
          rd & 32'h0000_070f);
      ahb(1'b0, cts_pkg::CTS_OFF_STATUS, 32'h0, rd);
      chk("timing legal", {31'h0, tm_rows[i].ok}, rd & 32'h1);
      strobe_gap(n);
      chk("bit length", (tm_rows[i].s1 + tm_rows[i].s2 + 3) *
          (tm_rows[i].pr + 1), n);
    end
    p.bus_level(1'b0);
    repeat (40) @(posedge hclk);
    #1;
    chk("sampled dominant", 32'h0, {31'h0, sampled_bit});
    p.bus_level(1'b1);
    ahb(1'b1, cts_pkg::CTS_OFF_STAMP_CTRL, 32'h1, rd);
    p.pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 6'h00);
    p.pulse(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 6'h00);
    tog(1'b1);
    ahb(1'b1, cts_pkg::CTS_OFF_STAMP_CTRL, 32'h5, rd);
    p.pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 6'h05);
    p.pulse(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 6'h00);
    tog(1'b1);
    p.pulse(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 6'h00);
    p.pulse(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 6'h00);
    tog(1'b1);
    p.pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 6'h00);
    ahb(1'b0, cts_pkg::CTS_OFF_STAMP_CTRL, 32'h0, rd);
    chk("lock clears enable", {23'h0, exp_tog, 8'h04}, rd);
    p.pulse(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 6'h00);
    tog(1'b0);
    chk("toggle edges", flips, p.edges);
    give_verdict();
  end
endmodule : can_time_stamp_and_bit_timing_bench
`default_nettype wire
